// *** logic/cpp_top.sv ***
// Processor support: pointers, wide register access and change protection
//
// Register access over APB is this design's own decision.
`timescale 1ns/100ps
module cpp_top #(
	parameter int AW = 12,
	parameter logic [15:0] SP_RESET = cpp_pkg::RST_SP
) (
	input wire logic clock, // Core clock, 100 MHz
	input wire logic rst, // Async reset, high
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [AW-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [3:0] pstrb, // APB write strobes
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic insn_done, // One instruction retired
	input wire logic cpu_mem_wr, // Core write to io or data memory
	input wire logic nvm_access, // Core access to flash, nvm or eeprom
	input wire logic sleep_exec, // Sleep instruction executed
	input wire logic irq_pending, // Interrupt request pending
	output logic irq_take_q, // Interrupt may be serviced
	output logic io_unlock_q, // Protected io writes allowed
	output logic spm_unlock_q, // Protected store allowed
	input wire logic sp_ld, // Core loads stack pointer
	input wire logic [15:0] sp_in, // Stack pointer load value
	output logic [15:0] sp_q, // Stack pointer
	input wire logic status_flags_ld, // Core loads status flags
	input wire logic [7:0] status_flags_in, // Status flags load value
	output logic [7:0] status_flags_q, // Status flags
	input wire logic rf_wr_en, // Register write strobe
	input wire logic [4:0] rf_wr_idx, // Register to write
	input wire logic [7:0] rf_wr_data, // Register write data
	input wire logic [4:0] rf_rd_idx, // Register to read
	output logic [7:0] rf_rd_data_q, // Register read data
	input wire logic ptr_req, // Address generation strobe
	input wire cpp_pkg::cpp_ptr_sel_t ptr_sel, // Pointer select
	input wire cpp_pkg::cpp_ptr_mode_t ptr_mode, // Addressing mode
	input wire cpp_pkg::cpp_ptr_kind_t ptr_kind, // Instruction kind
	input wire logic [5:0] ptr_disp, // Displacement
	output logic [15:0] addr_q, // Generated address
	output logic addr_valid_q, // Address valid pulse
	output logic ptr_err_q // Illegal pointer pulse
);
	typedef enum {SEL_NONE, SEL_CCP, SEL_SPL, SEL_SPH, SEL_STATUS_FLAGS, SEL_TMP}
		cpp_sel_t;
	typedef struct packed {
		cpp_pkg::cpp_win_t win;
		logic [2:0] cnt;
		logic io;
		logic self_program_mode;
		logic [7:0] status_flags;
		logic irq_take;
		logic rdy;
		logic err;
		logic [31:0] rdata;
	} cpp_top_st_t;
	cpp_top_st_t s_q;
	cpp_top_st_t s_d;
	cpp_sel_t sel;
	logic setup;
	logic acc;
	logic wr;
	logic rd;
	logic sig_wr;
	logic io_wr_other;
	logic [7:0] sp_tmp;

	// Working registers have no bus index, so no access can reach them
	function automatic cpp_sel_t decode(input logic [AW-1:0] a);
		logic [AW-3:0] idx;
		idx = a[AW-1:2];
		if (a[1:0] != 2'b00) begin
			decode = SEL_NONE;
		end else if (idx == (AW-2)'(cpp_pkg::IDX_CCP)) begin
			decode = SEL_CCP;
		end else if (idx == (AW-2)'(cpp_pkg::IDX_SPL)) begin
			decode = SEL_SPL;
		end else if (idx == (AW-2)'(cpp_pkg::IDX_SPH)) begin
			decode = SEL_SPH;
		end else if (idx == (AW-2)'(cpp_pkg::IDX_STATUS_FLAGS)) begin
			decode = SEL_STATUS_FLAGS;
		end else if (idx == (AW-2)'(cpp_pkg::IDX_TMP)) begin
			decode = SEL_TMP; // RL10
		end else begin
			decode = SEL_NONE; // RL1
		end
	endfunction

	assign sel = decode(paddr);
	assign setup = psel && !penable;
	assign acc = psel && penable && s_q.rdy;
	assign wr = acc && pwrite && pstrb[0] && sel != SEL_NONE;
	assign rd = acc && !pwrite;
	assign sig_wr = wr && sel == SEL_CCP
		&& (pwdata[7:0] == cpp_pkg::SIG_IO
		|| pwdata[7:0] == cpp_pkg::SIG_SPM); // RL23
	assign io_wr_other = wr && sel != SEL_CCP;

	cpp_wide16 #(
		.RESET_VAL(SP_RESET)
	) u_sp (
		.clock(clock),
		.rst(rst),
		.wr_lo(wr && sel == SEL_SPL), // RL6
		.wr_hi(wr && sel == SEL_SPH),
		.rd_lo(rd && sel == SEL_SPL),
		.wr_tmp(wr && sel == SEL_TMP),
		.din(pwdata[7:0]),
		.hw_ld(sp_ld),
		.hw_val(sp_in),
		.val_q(sp_q),
		.tmp_q(sp_tmp)
	);

	cpp_ptr_regs u_rf (
		.clock(clock),
		.rst(rst),
		.wr_en(rf_wr_en),
		.wr_idx(rf_wr_idx),
		.wr_data(rf_wr_data),
		.rd_idx(rf_rd_idx),
		.rd_data_q(rf_rd_data_q),
		.ptr_req(ptr_req),
		.ptr_sel(ptr_sel),
		.ptr_mode(ptr_mode),
		.ptr_kind(ptr_kind),
		.ptr_disp(ptr_disp),
		.addr_q(addr_q),
		.addr_valid_q(addr_valid_q),
		.ptr_err_q(ptr_err_q)
	);

	always_comb begin
		s_d = s_q;
		// Zero-wait slave: ready is raised for exactly one access cycle
		s_d.rdy = setup;
		if (setup) begin
			s_d.err = sel == SEL_NONE;
			if (sel == SEL_CCP) begin
				s_d.rdata = {30'h0, s_q.self_program_mode, s_q.io}; // RL22
			end else if (sel == SEL_SPL) begin
				s_d.rdata = {24'h000000, sp_q[7:0]};
			end else if (sel == SEL_SPH) begin
				s_d.rdata = {24'h000000, sp_tmp}; // RL8
			end else if (sel == SEL_STATUS_FLAGS) begin
				s_d.rdata = {24'h000000, s_q.status_flags};
			end else if (sel == SEL_TMP) begin
				s_d.rdata = {24'h000000, sp_tmp}; // RL10
			end else begin
				s_d.rdata = 32'h00000000;
			end
		end else if (acc) begin
			s_d.err = 1'b0;
		end
		if (status_flags_ld) begin
			s_d.status_flags = status_flags_in;
		end
		if (wr && sel == SEL_STATUS_FLAGS) begin
			s_d.status_flags = pwdata[7:0];
		end
		case (s_q.win)
			cpp_pkg::ST_IO: begin
				if (cpu_mem_wr || nvm_access || sleep_exec || io_wr_other) begin
					s_d.win = cpp_pkg::ST_IDLE; // RL16
				end else if (insn_done) begin
					if (s_q.cnt <= 3'h1) begin
						s_d.win = cpp_pkg::ST_IDLE; // RL24
					end
					s_d.cnt = s_q.cnt - 3'h1;
				end
			end
			cpp_pkg::ST_SPM: begin
				if (nvm_access || sleep_exec) begin
					s_d.win = cpp_pkg::ST_IDLE; // RL18
				end else if (insn_done) begin
					if (s_q.cnt <= 3'h1) begin
						s_d.win = cpp_pkg::ST_IDLE; // RL24
					end
					s_d.cnt = s_q.cnt - 3'h1;
				end
			end
			default: begin
				s_d.cnt = 3'h0;
			end
		endcase
		// A new signature restarts the count; the key write itself is
		// not one of the counted instructions
		if (sig_wr) begin
			s_d.cnt = cpp_pkg::WIN_INSNS; // RL24
			if (pwdata[7:0] == cpp_pkg::SIG_IO) begin
				s_d.win = cpp_pkg::ST_IO; // RL13 RL21
			end else begin
				s_d.win = cpp_pkg::ST_SPM; // RL13 RL21
			end
		end
		s_d.io = s_d.win == cpp_pkg::ST_IO; // RL12
		s_d.self_program_mode = s_d.win == cpp_pkg::ST_SPM; // RL12
		// Requests stay pending upstream; only the grant is withheld
		s_d.irq_take = irq_pending && s_d.status_flags[cpp_pkg::STATUS_FLAGS_I_BIT]
			&& s_d.win == cpp_pkg::ST_IDLE; // RL19 RL20
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '{win: cpp_pkg::ST_IDLE, cnt: 3'h0, io: 1'b0, self_program_mode: 1'b0,
				status_flags: cpp_pkg::RST_STATUS_FLAGS, irq_take: 1'b0, rdy: 1'b0,
				err: 1'b0, rdata: 32'h00000000};
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.rdy;
	assign pslverr = s_q.err;
	assign irq_take_q = s_q.irq_take;
	assign io_unlock_q = s_q.io;
	assign spm_unlock_q = s_q.self_program_mode;
	assign status_flags_q = s_q.status_flags;

	AST_SIG_IO: assert property (@(posedge clock) disable iff (rst) // RL21
		wr && sel == SEL_CCP && pwdata[7:0] == cpp_pkg::SIG_IO
		|=> io_unlock_q && !spm_unlock_q)
		else $error("io signature did not open io window");
	AST_SIG_SPM: assert property (@(posedge clock) disable iff (rst) // RL21
		wr && sel == SEL_CCP && pwdata[7:0] == cpp_pkg::SIG_SPM
		|=> spm_unlock_q && !io_unlock_q)
		else $error("program signature did not open program window");
	AST_BAD_SIG: assert property (@(posedge clock) disable iff (rst) // RL23
		wr && sel == SEL_CCP && !sig_wr && !io_unlock_q && !spm_unlock_q
		|=> !io_unlock_q && !spm_unlock_q)
		else $error("bad key value opened a window");
	AST_CCP_READ: assert property (@(posedge clock) disable iff (rst) // RL22
		setup && sel == SEL_CCP
		|=> prdata == {30'h0, $past(spm_unlock_q), $past(io_unlock_q)})
		else $error("key register read value wrong");
	AST_WIN_LIVE: assert property (@(posedge clock) disable iff (rst) // RL24
		sig_wr && pwdata[7:0] == cpp_pkg::SIG_IO ##1
		(insn_done && !cpu_mem_wr && !nvm_access && !sleep_exec && !wr)[*3]
		|=> io_unlock_q)
		else $error("io window closed before fourth instruction");
	AST_WIN_EXPIRE: assert property (@(posedge clock) disable iff (rst) // RL24
		sig_wr && pwdata[7:0] == cpp_pkg::SIG_IO ##1
		(insn_done && !cpu_mem_wr && !nvm_access && !sleep_exec && !wr)[*4]
		|=> !io_unlock_q)
		else $error("io window outlived four instructions");
	AST_IO_CLOSE: assert property (@(posedge clock) disable iff (rst) // RL16
		io_unlock_q && (cpu_mem_wr || nvm_access || sleep_exec) && !sig_wr
		|=> !io_unlock_q)
		else $error("io window survived a closing event");
	AST_SPM_CLOSE: assert property (@(posedge clock) disable iff (rst) // RL18
		spm_unlock_q && (nvm_access || sleep_exec) && !sig_wr
		|=> !spm_unlock_q)
		else $error("program window survived a closing event");
	AST_IRQ_HOLD: assert property (@(posedge clock) disable iff (rst) // RL19
		io_unlock_q || spm_unlock_q |-> !irq_take_q)
		else $error("interrupt granted inside protection window");
	AST_IRQ_RESUME: assert property (@(posedge clock) disable iff (rst) // RL20
		!io_unlock_q && !spm_unlock_q && irq_pending && !sig_wr && !status_flags_ld
		&& !(wr && sel == SEL_STATUS_FLAGS) && status_flags_q[cpp_pkg::STATUS_FLAGS_I_BIT]
		|=> irq_take_q)
		else $error("pending interrupt not granted outside window");
endmodule

// *** inc/cpp_pkg.sv ***
// Constants and types shared by the pointer, wide-register and protect logic
// Function
// RL1 - Working registers unreachable by data memory accesses
// RL2 - Top six registers form three 16-bit pointers
// RL3 - Program load and indirect jumps use pointer_c only
// RL4 - Lower register is low byte of pointer
// RL5 - Pointers support displacement, post-increment, pre-decrement
// RL6 - Wide registers reached through shared temporary byte
// RL7 - Low write to temp; high write commits both
// RL8 - Low read captures high byte into temp
// RL9 - Software accesses low byte before high byte
// RL10 - Temporary byte register directly readable and writable
// RL11 - Software masks interrupts around two-byte accesses
// RL12 - Protected changes need a prior valid signature
// RL13 - Two unlock modes: protected io, self program
// RL14 - Software writes protected register within four instructions
// RL15 - Software sets change-enable bit in same write
// RL16 - Io window closes on writes, nvm access, sleep
// RL17 - Software runs protected store within four instructions
// RL18 - Program window closes on nvm access or sleep
// RL19 - No interrupt serviced while window is open
// RL20 - Pending interrupts serviced once window closes
// RL21 - 0x9d opens program mode, 0xd8 opens io mode
// RL22 - Key reads mode bits 1:0, bits 7:2 zero
// RL23 - Other key values change no protection state
// RL24 - Window counts four executed instructions, then expires
package cpp_pkg;
	localparam logic [7:0] SIG_SPM = 8'h9d;
	localparam logic [7:0] SIG_IO = 8'hd8;
	localparam logic [7:0] IDX_CCP = 8'h04;
	localparam logic [7:0] IDX_SPL = 8'h0d;
	localparam logic [7:0] IDX_SPH = 8'h0e;
	localparam logic [7:0] IDX_STATUS_FLAGS = 8'h0f;
	localparam logic [7:0] IDX_TMP = 8'h10;
	localparam int CCP_IO_BIT = 0;
	localparam int CCP_SPM_BIT = 1;
	localparam int STATUS_FLAGS_I_BIT = 7;
	localparam logic [2:0] WIN_INSNS = 3'h4;
	localparam logic [7:0] RST_STATUS_FLAGS = 8'h00;
	localparam logic [15:0] RST_SP = 16'h0000;
	localparam logic [4:0] PTR_A_LO = 5'h1a;
	typedef enum logic [1:0] {PTR_A, PTR_B, PTR_C} cpp_ptr_sel_t;
	typedef enum logic [1:0] {MODE_DISP, MODE_POSTINC, MODE_PREDEC}
		cpp_ptr_mode_t;
	typedef enum logic [1:0] {KIND_LDST, KIND_PMLOAD, KIND_INDIRECT}
		cpp_ptr_kind_t;
	typedef enum {ST_IDLE, ST_IO, ST_SPM} cpp_win_t;
endpackage

// *** logic/cpp_ptr_regs.sv ***
// Working register file with pointer address generation
`timescale 1ns/100ps
module cpp_ptr_regs (
	input wire logic clock, // Core clock
	input wire logic rst, // Async reset, high
	input wire logic wr_en, // Register write strobe
	input wire logic [4:0] wr_idx, // Register number to write
	input wire logic [7:0] wr_data, // Write data
	input wire logic [4:0] rd_idx, // Register number to read
	output logic [7:0] rd_data_q, // Read data, one cycle later
	input wire logic ptr_req, // Address generation strobe
	input wire cpp_pkg::cpp_ptr_sel_t ptr_sel, // Pointer select
	input wire cpp_pkg::cpp_ptr_mode_t ptr_mode, // Addressing mode
	input wire cpp_pkg::cpp_ptr_kind_t ptr_kind, // Instruction kind
	input wire logic [5:0] ptr_disp, // Unsigned displacement
	output logic [15:0] addr_q, // Generated address
	output logic addr_valid_q, // Address valid pulse
	output logic ptr_err_q // Illegal pointer pulse
);
	typedef struct packed {
		logic [31:0][7:0] regs;
		logic [7:0] rd;
		logic [15:0] addr;
		logic vld;
		logic err;
	} cpp_rf_st_t;
	cpp_rf_st_t s_q;
	cpp_rf_st_t s_d;
	logic [4:0] lo;
	logic [4:0] hi;
	logic [15:0] base;
	logic [15:0] nb;

	function automatic logic [4:0] lo_idx(input cpp_pkg::cpp_ptr_sel_t sel);
		lo_idx = cpp_pkg::PTR_A_LO + {2'h0, sel, 1'b0}; // RL2
	endfunction

	assign lo = lo_idx(ptr_sel);
	assign hi = {lo[4:1], 1'b1};
	assign base = {s_q.regs[hi], s_q.regs[lo]}; // RL4

	always_comb begin
		s_d = s_q;
		nb = base;
		s_d.vld = 1'b0;
		s_d.err = 1'b0;
		s_d.rd = s_q.regs[rd_idx];
		if (wr_en) begin
			s_d.regs[wr_idx] = wr_data;
		end
		if (ptr_req) begin
			if (ptr_kind != cpp_pkg::KIND_LDST && ptr_sel != cpp_pkg::PTR_C) begin
				s_d.err = 1'b1; // RL3
			end else if (ptr_kind == cpp_pkg::KIND_INDIRECT) begin
				s_d.addr = base; // RL3
				s_d.vld = 1'b1;
			end else begin
				s_d.vld = 1'b1;
				case (ptr_mode)
					cpp_pkg::MODE_POSTINC: begin
						s_d.addr = base; // RL5
						nb = base + 16'h0001;
					end
					cpp_pkg::MODE_PREDEC: begin
						nb = base - 16'h0001; // RL5
						s_d.addr = nb;
					end
					default: begin
						s_d.addr = base + {10'h000, ptr_disp}; // RL5
					end
				endcase
				// Pointer update overrides a plain write to the same register
				s_d.regs[lo] = nb[7:0];
				s_d.regs[hi] = nb[15:8];
			end
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data_q = s_q.rd;
	assign addr_q = s_q.addr;
	assign addr_valid_q = s_q.vld;
	assign ptr_err_q = s_q.err;

	AST_PTR_C_ONLY: assert property (@(posedge clock) disable iff (rst) // RL3
		ptr_req && ptr_kind != cpp_pkg::KIND_LDST && ptr_sel != cpp_pkg::PTR_C
		|=> ptr_err_q && !addr_valid_q)
		else $error("non-c pointer accepted for program load or jump");
	AST_BYTE_ORDER: assert property (@(posedge clock) disable iff (rst) // RL4
		ptr_req && ptr_kind == cpp_pkg::KIND_INDIRECT && ptr_sel == cpp_pkg::PTR_C
		|=> addr_valid_q && addr_q == {$past(s_q.regs[31]), $past(s_q.regs[30])})
		else $error("indirect target byte order wrong");
	AST_POSTINC: assert property (@(posedge clock) disable iff (rst) // RL5
		ptr_req && ptr_kind == cpp_pkg::KIND_LDST
		&& ptr_mode == cpp_pkg::MODE_POSTINC
		|=> addr_q == $past(base) && base == $past(base) + 16'h0001)
		else $error("post-increment address or update wrong");
endmodule

// *** logic/cpp_wide16.sv ***
// Sixteen-bit register reached byte-wise through a shared temporary byte
`timescale 1ns/100ps
module cpp_wide16 #(
	parameter logic [15:0] RESET_VAL = cpp_pkg::RST_SP
) (
	input wire logic clock, // Core clock
	input wire logic rst, // Async reset, high
	input wire logic wr_lo, // Low byte write strobe
	input wire logic wr_hi, // High byte write strobe
	input wire logic rd_lo, // Low byte read strobe
	input wire logic wr_tmp, // Direct temp write strobe
	input wire logic [7:0] din, // Byte write data
	input wire logic hw_ld, // Parallel load from the core
	input wire logic [15:0] hw_val, // Parallel load value
	output logic [15:0] val_q, // Register value
	output logic [7:0] tmp_q // Temporary byte
);
	typedef struct packed {
		logic [15:0] val;
		logic [7:0] tmp;
	} cpp_w16_st_t;
	cpp_w16_st_t s_q;
	cpp_w16_st_t s_d;

	always_comb begin
		s_d = s_q;
		if (hw_ld) begin
			s_d.val = hw_val;
		end
		if (wr_lo || wr_tmp) begin
			s_d.tmp = din; // RL7 RL10
		end else if (rd_lo) begin
			s_d.tmp = s_q.val[15:8]; // RL8
		end
		if (wr_hi) begin
			s_d.val = {din, s_q.tmp}; // RL7
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_q <= '{val: RESET_VAL, tmp: 8'h00};
		end else begin
			s_q <= s_d;
		end
	end

	assign val_q = s_q.val;
	assign tmp_q = s_q.tmp;

	AST_WRITE_PAIR: assert property (@(posedge clock) disable iff (rst) // RL7
		wr_hi && !wr_lo && !wr_tmp
		|=> val_q == {$past(din), $past(tmp_q)})
		else $error("high write did not commit captured low byte");
	AST_READ_CAPTURE: assert property (@(posedge clock) disable iff (rst) // RL8
		rd_lo && !wr_lo && !wr_tmp |=> tmp_q == $past(val_q[15:8]))
		else $error("low read did not capture high byte");
endmodule

// *** bench/cpp_core_model.sv ***
// Core stand-in that retires a burst of instructions on request
`timescale 1ns/100ps
module cpp_core_model (
	input wire logic clock, // Core clock
	input wire logic rst, // Async reset, high
	input wire logic start, // Begin a burst
	input wire logic [2:0] cnt, // Instructions in the burst
	input wire logic gap, // Idle cycle between instructions
	output logic insn_done // One instruction retired
);
	logic [2:0] left_q;
	logic wait_q;
	// Burst length is set by the bench so the window is used in time
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			left_q <= 3'h0;
			wait_q <= 1'b0;
			insn_done <= 1'b0;
		end else if (start) begin
			left_q <= cnt;
			wait_q <= 1'b0;
			insn_done <= 1'b0;
		end else if (left_q != 3'h0 && !wait_q) begin
			insn_done <= 1'b1;
			left_q <= left_q - 3'h1;
			wait_q <= gap;
		end else begin
			insn_done <= 1'b0;
			wait_q <= 1'b0;
		end
	end
endmodule

// *** bench/tb_cpu_pointer_atomic_access_protect.sv ***
// Self-checking bench for pointers, wide register access and protection
`timescale 1ns/100ps
module tb_cpu_pointer_atomic_access_protect;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic [3:0] pstrb = 4'h1;
	logic err_v, start = 1'b0, gap = 1'b0, insn_done;
	logic [2:0] evt = 3'h0;
	logic irq_pending = 1'b1, sp_ld = 1'b0, status_flags_ld = 1'b0;
	logic [15:0] sp_in = 16'h0, sp_q, addr_q;
	logic [7:0] status_flags_in = 8'h0, status_flags_q, rf_wr_data = 8'h0;
	logic [7:0] rf_rd_data_q;
	logic irq_take_q, io_unlock_q, spm_unlock_q, rf_wr_en = 1'b0;
	logic [4:0] rf_wr_idx = 5'h0, rf_rd_idx = 5'h1c;
	logic ptr_req = 1'b0, addr_valid_q, ptr_err_q;
	cpp_pkg::cpp_ptr_sel_t ptr_sel = cpp_pkg::PTR_A;
	cpp_pkg::cpp_ptr_mode_t ptr_mode = cpp_pkg::MODE_DISP;
	cpp_pkg::cpp_ptr_kind_t ptr_kind = cpp_pkg::KIND_LDST;
	logic [5:0] ptr_disp = 6'h0;
	int err_total = 0, num_checks = 0;

	always #5 clock = ~clock;

	cpp_top #(.AW(12), .SP_RESET(16'h0000)) i_cpp_top (.clock, .rst,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .insn_done, .cpu_mem_wr(evt[0]), .nvm_access(evt[1]),
		.sleep_exec(evt[2]), .irq_pending, .irq_take_q, .io_unlock_q,
		.spm_unlock_q, .sp_ld, .sp_in, .sp_q, .status_flags_ld, .status_flags_in,
		.status_flags_q, .rf_wr_en, .rf_wr_idx, .rf_wr_data, .rf_rd_idx,
		.rf_rd_data_q, .ptr_req, .ptr_sel, .ptr_mode, .ptr_kind, .ptr_disp,
		.addr_q, .addr_valid_q, .ptr_err_q);

	cpp_core_model i_cpp_core_model (.clock, .rst, .start, .cnt(3'h4), .gap,
		.insn_done);

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] idx,
		input logic [7:0] d);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) err_total++;
		rdv = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask

	task automatic ev(input int e);
		@(posedge clock);
		evt[e] <= 1'b1;
		@(posedge clock);
		evt <= 3'h0;
		#1;
	endtask

	task automatic insn();
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (insn_done !== 1'b1 && n < 20);
		if (n == 20) err_total++;
		#1;
	endtask

	task automatic ptr(input logic [1:0] s, input logic [1:0] m,
		input logic [1:0] k, input logic [5:0] d, input logic [15:0] ea,
		input logic er);
		@(posedge clock);
		ptr_req <= 1'b1;
		ptr_sel <= cpp_pkg::cpp_ptr_sel_t'(s);
		ptr_mode <= cpp_pkg::cpp_ptr_mode_t'(m);
		ptr_kind <= cpp_pkg::cpp_ptr_kind_t'(k);
		ptr_disp <= d;
		@(posedge clock);
		ptr_req <= 1'b0;
		#1;
		chk(ptr_err_q, er);
		chk(addr_valid_q, !er);
		if (!er) chk(addr_q, ea);
	endtask

	task automatic t_reset();
		chk(io_unlock_q, 1'b0);
		chk(spm_unlock_q, 1'b0);
		apb(1'b0, cpp_pkg::IDX_CCP, 8'h00);
		chk(rdv, 32'h0);
		apb(1'b0, 8'h1a, 8'h00);
		chk(err_v, 1'b1);
		chk(rdv, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_sp();
		// Low byte before high byte, both ways
		// Interrupt enable is still clear here, so no handler can intrude
		apb(1'b1, cpp_pkg::IDX_SPL, 8'h34);
		chk(sp_q, 16'h0000);
		apb(1'b0, cpp_pkg::IDX_TMP, 8'h00);
		chk(rdv, 32'h34);
		apb(1'b1, cpp_pkg::IDX_SPH, 8'h12);
		chk(sp_q, 16'h1234);
		apb(1'b1, cpp_pkg::IDX_TMP, 8'h77);
		apb(1'b1, cpp_pkg::IDX_SPH, 8'h56);
		chk(sp_q, 16'h5677);
		@(posedge clock);
		sp_ld <= 1'b1;
		sp_in <= 16'habcd;
		@(posedge clock);
		sp_ld <= 1'b0;
		apb(1'b0, cpp_pkg::IDX_SPL, 8'h00);
		chk(rdv, 32'hcd);
		@(posedge clock);
		sp_ld <= 1'b1;
		sp_in <= 16'h0000;
		@(posedge clock);
		sp_ld <= 1'b0;
		apb(1'b0, cpp_pkg::IDX_SPH, 8'h00);
		chk(rdv, 32'hab);
		$display("test wide register done");
	endtask

	task automatic t_ptr();
		for (int i = 0; i < 6; i++) begin
			@(posedge clock);
			rf_wr_en <= 1'b1;
			rf_wr_idx <= 5'(26 + i);
			rf_wr_data <= 8'(16 + i);
		end
		@(posedge clock);
		rf_wr_en <= 1'b0;
		ptr(2'h0, 2'h0, 2'h0, 6'h3f, 16'h114f, 1'b0);
		ptr(2'h1, 2'h1, 2'h0, 6'h00, 16'h1312, 1'b0);
		ptr(2'h1, 2'h0, 2'h0, 6'h00, 16'h1313, 1'b0);
		ptr(2'h2, 2'h2, 2'h0, 6'h00, 16'h1513, 1'b0);
		ptr(2'h2, 2'h0, 2'h2, 6'h00, 16'h1513, 1'b0);
		ptr(2'h2, 2'h0, 2'h1, 6'h00, 16'h1513, 1'b0);
		ptr(2'h0, 2'h0, 2'h1, 6'h00, 16'h0000, 1'b1);
		ptr(2'h1, 2'h0, 2'h2, 6'h00, 16'h0000, 1'b1);
		chk(rf_rd_data_q, 8'h13);
		$display("test pointers done");
	endtask

	task automatic t_count();
		@(posedge clock);
		status_flags_ld <= 1'b1;
		status_flags_in <= 8'h80;
		@(posedge clock);
		status_flags_ld <= 1'b0;
		#1;
		chk(irq_take_q, 1'b1);
		// A fast burst and a slow burst prove the window counts instructions, not cycles
		for (int g = 0; g < 2; g++) begin
			apb(1'b1, cpp_pkg::IDX_CCP, cpp_pkg::SIG_IO);
			chk(io_unlock_q, 1'b1);
			chk(irq_take_q, 1'b0);
			apb(1'b0, cpp_pkg::IDX_CCP, 8'h00);
			chk(rdv, 32'h1);
			@(posedge clock);
			start <= 1'b1;
			gap <= g[0];
			@(posedge clock);
			start <= 1'b0;
			repeat (3) insn();
			chk(io_unlock_q, 1'b1);
			insn();
			chk(io_unlock_q, 1'b0);
			chk(irq_take_q, 1'b1);
		end
		$display("test window count done");
	endtask

	task automatic t_close();
		for (int e = 0; e < 3; e++) begin
			apb(1'b1, cpp_pkg::IDX_CCP, cpp_pkg::SIG_IO);
			apb(1'b1, cpp_pkg::IDX_CCP, 8'h55);
			chk(io_unlock_q, 1'b1);
			ev(e);
			chk(io_unlock_q, 1'b0);
		end
		apb(1'b1, cpp_pkg::IDX_CCP, cpp_pkg::SIG_IO);
		apb(1'b1, cpp_pkg::IDX_TMP, 8'h00);
		chk(io_unlock_q, 1'b0);
		apb(1'b1, cpp_pkg::IDX_CCP, 8'h55);
		chk(io_unlock_q | spm_unlock_q, 1'b0);
		for (int e = 0; e < 3; e++) begin
			apb(1'b1, cpp_pkg::IDX_CCP, cpp_pkg::SIG_SPM);
			chk(spm_unlock_q, 1'b1);
			chk(io_unlock_q, 1'b0);
			chk(irq_take_q, 1'b0);
			ev(e);
			chk(spm_unlock_q, e == 0);
		end
		apb(1'b1, cpp_pkg::IDX_CCP, cpp_pkg::SIG_SPM);
		apb(1'b0, cpp_pkg::IDX_CCP, 8'h00);
		chk(rdv, 32'h2);
		$display("test window close done");
	endtask

	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		#1;
		t_reset();
		t_sp();
		t_ptr();
		t_count();
		t_close();
		conclude();
	end

	initial begin
		#200000;
		err_total++;
		conclude();
	end
endmodule
